// file: src/ufc_consts.svh
// constants of the uart fifo control block
`ifndef UFC_CONSTS_SVH
`define UFC_CONSTS_SVH
// register byte addresses
`define UFC_ADDR_SETUP 12'h000
`define UFC_ADDR_STATUS 12'h004
`define UFC_ADDR_IRQ_STAT 12'h008
`define UFC_ADDR_IRQ_CLR 12'h00C
`define UFC_ADDR_IRQ_EN 12'h010
// setup field positions
`define UFC_BIT_FEN 0
`define UFC_BIT_RXCLR 1
`define UFC_BIT_TXCLR 2
`define UFC_BIT_DMA 3
`define UFC_BIT_THR_LSB 6
`define UFC_BIT_THR_MSB 7
// setup reset value
`define UFC_SETUP_RESET 8'h00
// trigger levels in bytes
`define UFC_TRIG_1 5'h01
`define UFC_TRIG_4 5'h04
`define UFC_TRIG_8 5'h08
`define UFC_TRIG_14 5'h0E
// interrupt event bits
`define UFC_EV_TRIG 0
`define UFC_EV_TXEMPTY 1
`define UFC_EV_OVERRUN 2
`define UFC_EV_W 3
// status field positions
`define UFC_STAT_RX_LSB 8
`define UFC_STAT_TX_LSB 16
`endif

// file: src/ufc_fifo_ctrl.sv
// fifo control, dma ready pins and apb registers of the uart
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ufc_consts.svh"

// How it works
// R1: receive interrupt when count equals trigger level
// R2: receive fifo keeps filling until full
// R3: setup bit 3 picks dma mode
// R4: mode 0 tx ready low while empty
// R5: mode 0 rx ready low while data held
// R6: mode 1 tx ready high full, low empty
// R7: mode 1 rx ready low at trigger/timeout
// R8: setup bit 2 empties transmit fifo
// R9: setup bit 1 empties receive fifo
// R10: clear bits return to zero by themselves
// R11: setup bit 0 enables both fifos
// R12: other bits written only with enable set
// R13: trigger codes give 1,4,8,14 bytes
// R14: receive interrupt drops below trigger level
// R15: mode 1 tx ready holds between full/empty
// R16: all setup fields zero after reset
module ufc_fifo_ctrl import ufc_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // transmit side: host load, serializer take
  input wire logic TX_LOAD_I,
  input wire logic [WIDTH-1:0] TX_DATA_I,
  input wire logic TX_TAKE_I,
  output logic [WIDTH-1:0] TX_HEAD_O,
  output logic TX_HAS_DATA_O,
  // receive side: deserializer store, host read
  input wire logic RX_STORE_I,
  input wire logic [WIDTH-1:0] RX_DATA_I,
  input wire logic RX_READ_I,
  input wire logic RX_TIMEOUT_I,
  output logic [WIDTH-1:0] RX_HEAD_O,
  // dma ready pins and interrupts
  output logic TX_SPACE_AVAIL_N_O,
  output logic RX_CHAR_AVAIL_N_O,
  output logic RX_DATA_IRQ_O,
  output logic IRQ_O
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] fifo_setup, next_fifo_setup; // enable, dma, threshold; clear bits read 0
  logic tx_clear, rx_clear, next_tx_clear, next_rx_clear; // one-cycle clear pulses
  logic [`UFC_EV_W-1:0] irq_stat, next_irq_stat; // sticky events
  logic [`UFC_EV_W-1:0] irq_en, next_irq_en;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic wr_acc, fen, dma1; // write access phase, fifos enabled, block mode

  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && !PREADY_O;
  assign fen = fifo_setup[`UFC_BIT_FEN];
  assign dma1 = fen && fifo_setup[`UFC_BIT_DMA]; // R3

  // ************************************************************
  // fifo storage
  // ************************************************************
  logic [WIDTH-1:0] tx_mem [DEPTH], rx_mem [DEPTH]; // transmit and receive storage
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp, next_tx_wp, next_tx_rp, next_rx_wp, next_rx_rp;
  logic [AW:0] tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
  logic [AW:0] cap; // 1 when single-character mode
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic [4:0] trig; // trigger level bytes

  // capacity shrinks to one holding register when disabled
  assign cap = fen ? FULL_CNT : (AW+1)'(1); // R11
  assign tx_push = TX_LOAD_I && (tx_cnt < cap) && !tx_clear;
  assign tx_pop = TX_TAKE_I && (tx_cnt != '0) && !tx_clear;
  // stores continue past the trigger until full
  assign rx_push = RX_STORE_I && (rx_cnt < cap) && !rx_clear; // R2
  assign rx_pop = RX_READ_I && (rx_cnt != '0) && !rx_clear;

  // trigger level decode
  always_comb begin
    unique case (fifo_setup[`UFC_BIT_THR_MSB:`UFC_BIT_THR_LSB]) // R13
      2'b00: trig = `UFC_TRIG_1;
      2'b01: trig = `UFC_TRIG_4;
      2'b10: trig = `UFC_TRIG_8;
      2'b11: trig = `UFC_TRIG_14;
    endcase
  end

  // pointer and counter next values
  always_comb begin
    next_tx_wp = tx_wp;
    next_tx_rp = tx_rp;
    next_tx_cnt = tx_cnt;
    next_rx_wp = rx_wp;
    next_rx_rp = rx_rp;
    next_rx_cnt = rx_cnt;
    if (tx_clear) begin // R8
      next_tx_wp = '0;
      next_tx_rp = '0;
      next_tx_cnt = '0;
    end else begin
      if (tx_push) next_tx_wp = AW'(tx_wp + 1'b1);
      if (tx_pop) next_tx_rp = AW'(tx_rp + 1'b1);
      next_tx_cnt = (AW+1)'(tx_cnt + tx_push - tx_pop);
    end
    if (rx_clear) begin // R9
      next_rx_wp = '0;
      next_rx_rp = '0;
      next_rx_cnt = '0;
    end else begin
      if (rx_push) next_rx_wp = AW'(rx_wp + 1'b1);
      if (rx_pop) next_rx_rp = AW'(rx_rp + 1'b1);
      next_rx_cnt = (AW+1)'(rx_cnt + rx_push - rx_pop);
    end
  end

  // pointer registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
      tx_cnt <= next_tx_cnt;
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
      rx_cnt <= next_rx_cnt;
    end
  end

  // storage writes, no reset needed on data
  always_ff @(posedge CLK_I) begin
    if (tx_push) tx_mem[tx_wp] <= TX_DATA_I;
    if (rx_push) rx_mem[rx_wp] <= RX_DATA_I;
  end

  // ************************************************************
  // ready pins, interrupt condition, outputs
  // ************************************************************
  ufc_rx_state_t rx_state, next_rx_state; // block mode rx ready
  logic next_tx_rdy_n, next_rx_rdy_n, next_rx_irq, next_irq, next_tx_has;
  logic [WIDTH-1:0] next_tx_head, next_rx_head;

  // pin and flag next values computed from the new occupancy
  always_comb begin
    next_rx_state = rx_state;
    next_tx_rdy_n = TX_SPACE_AVAIL_N_O;
    if (!dma1) begin
      next_tx_rdy_n = (next_tx_cnt != '0); // R4
      next_rx_rdy_n = (next_rx_cnt == '0); // R5
      next_rx_state = UFC_RX_IDLE;
    end else begin
      if (next_tx_cnt == FULL_CNT) next_tx_rdy_n = 1'b1; // R6
      else if (next_tx_cnt == '0) next_tx_rdy_n = 1'b0; // R6
      // otherwise keep the old level // R15
      unique case (rx_state)
        UFC_RX_IDLE: begin
          if ((next_rx_cnt >= (AW+1)'(trig)) || (RX_TIMEOUT_I && next_rx_cnt != '0)) begin
            next_rx_state = UFC_RX_ACTIVE; // R7
          end
        end
        UFC_RX_ACTIVE: begin
          if (next_rx_cnt == '0) next_rx_state = UFC_RX_IDLE; // R7
        end
      endcase
      next_rx_rdy_n = (next_rx_state == UFC_RX_IDLE);
    end
    // condition follows occupancy both ways
    next_rx_irq = fen ? (next_rx_cnt >= (AW+1)'(trig)) : (next_rx_cnt != '0); // R1 R14
    next_tx_head = tx_mem[next_tx_rp];
    next_rx_head = rx_mem[next_rx_rp];
    next_tx_has = (next_tx_cnt != '0);
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // pin registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_state <= UFC_RX_IDLE;
      TX_SPACE_AVAIL_N_O <= 1'b0;
      RX_CHAR_AVAIL_N_O <= 1'b1;
      RX_DATA_IRQ_O <= 1'b0;
      TX_HEAD_O <= '0;
      RX_HEAD_O <= '0;
      TX_HAS_DATA_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      TX_SPACE_AVAIL_N_O <= next_tx_rdy_n;
      RX_CHAR_AVAIL_N_O <= next_rx_rdy_n;
      RX_DATA_IRQ_O <= next_rx_irq;
      TX_HEAD_O <= next_tx_head;
      RX_HEAD_O <= next_rx_head;
      TX_HAS_DATA_O <= next_tx_has;
      IRQ_O <= next_irq;
    end
  end

  // ************************************************************
  // apb register file
  // ************************************************************
  logic [`UFC_EV_W-1:0] events; // event pulses
  logic rx_irq_rise;

  assign rx_irq_rise = next_rx_irq && !RX_DATA_IRQ_O;
  assign events = {RX_STORE_I && (rx_cnt == cap) && !rx_clear,
                   tx_pop && !tx_push && (tx_cnt == (AW+1)'(1)),
                   rx_irq_rise};

  // register next values
  always_comb begin
    next_fifo_setup = fifo_setup;
    next_tx_clear = 1'b0; // clear bits self-return after one cycle // R10
    next_rx_clear = 1'b0; // R10
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    next_prdata = '0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (wr_acc && PADDR_I == `UFC_ADDR_IRQ_CLR) next_irq_stat = irq_stat & ~PWDATA_I[`UFC_EV_W-1:0];
    next_irq_stat = next_irq_stat | events; // set beats clear
    if (PSEL_I && PENABLE_I && !PREADY_O) begin
      next_pready = 1'b1;
      unique case (PADDR_I)
        `UFC_ADDR_SETUP: begin
          if (PWRITE_I) begin
            next_fifo_setup[`UFC_BIT_FEN] = PWDATA_I[`UFC_BIT_FEN]; // R11
            if (PWDATA_I[`UFC_BIT_FEN]) begin // R12
              next_fifo_setup[`UFC_BIT_DMA] = PWDATA_I[`UFC_BIT_DMA]; // R3
              next_fifo_setup[`UFC_BIT_THR_MSB:`UFC_BIT_THR_LSB] =
                PWDATA_I[`UFC_BIT_THR_MSB:`UFC_BIT_THR_LSB];
              next_tx_clear = PWDATA_I[`UFC_BIT_TXCLR]; // R8
              next_rx_clear = PWDATA_I[`UFC_BIT_RXCLR]; // R9
            end
          end else next_prdata = {24'h00_0000, fifo_setup};
        end
        `UFC_ADDR_STATUS: if (!PWRITE_I) next_prdata =
          (32'(rx_cnt) << `UFC_STAT_RX_LSB) | (32'(tx_cnt) << `UFC_STAT_TX_LSB); // rx and tx occupancy
        `UFC_ADDR_IRQ_STAT: if (!PWRITE_I) next_prdata = 32'(irq_stat);
        `UFC_ADDR_IRQ_CLR: ;
        `UFC_ADDR_IRQ_EN: begin
          if (PWRITE_I) next_irq_en = PWDATA_I[`UFC_EV_W-1:0];
          else next_prdata = 32'(irq_en);
        end
        default: next_pslverr = 1'b1; // unmapped
      endcase
    end
  end

  // register flops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      fifo_setup <= `UFC_SETUP_RESET; // R16
      tx_clear <= 1'b0;
      rx_clear <= 1'b0;
      irq_en <= '0;
      irq_stat <= '0;
      PRDATA_O <= '0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      fifo_setup <= next_fifo_setup;
      tx_clear <= next_tx_clear;
      rx_clear <= next_rx_clear;
      irq_en <= next_irq_en;
      irq_stat <= next_irq_stat;
      PRDATA_O <= next_prdata;
      PREADY_O <= next_pready;
      PSLVERR_O <= next_pslverr;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_trig_irq;
    @(posedge CLK_I) disable iff (RST_I) (fen && rx_cnt == (AW+1)'(trig) && $stable(fifo_setup)) |-> RX_DATA_IRQ_O;
  endproperty
  a_trig_irq: assert property (p_trig_irq) else $error("rx irq missing at trigger"); // R1
  property p_below_trig;
    @(posedge CLK_I) disable iff (RST_I) (fen && rx_cnt < (AW+1)'(trig) && $stable(fifo_setup)) |-> !RX_DATA_IRQ_O;
  endproperty
  a_below_trig: assert property (p_below_trig) else $error("rx irq stays below trigger"); // R14
  property p_rx_fill;
    @(posedge CLK_I) disable iff (RST_I) (fen && rx_cnt < FULL_CNT && RX_STORE_I && !rx_clear && !RX_READ_I)
      |=> rx_cnt == $past(rx_cnt) + 1'b1;
  endproperty
  a_rx_fill: assert property (p_rx_fill) else $error("rx store dropped before full"); // R2
  property p_m0_tx;
    @(posedge CLK_I) disable iff (RST_I) (!dma1 && !$past(dma1)) |-> (TX_SPACE_AVAIL_N_O == (tx_cnt != '0));
  endproperty
  a_m0_tx: assert property (p_m0_tx) else $error("mode 0 tx ready wrong"); // R4
  property p_m0_rx;
    @(posedge CLK_I) disable iff (RST_I) (!dma1 && !$past(dma1)) |-> (RX_CHAR_AVAIL_N_O == (rx_cnt == '0));
  endproperty
  a_m0_rx: assert property (p_m0_rx) else $error("mode 0 rx ready wrong"); // R5
  property p_m1_full;
    @(posedge CLK_I) disable iff (RST_I) (dma1 && $past(dma1) && tx_cnt == FULL_CNT) |-> TX_SPACE_AVAIL_N_O;
  endproperty
  a_m1_full: assert property (p_m1_full) else $error("mode 1 tx ready low when full"); // R6
  property p_m1_rx_hold;
    @(posedge CLK_I) disable iff (RST_I) (dma1 && $past(dma1) && !RX_CHAR_AVAIL_N_O)
      |=> (!RX_CHAR_AVAIL_N_O || rx_cnt == '0);
  endproperty
  a_m1_rx_hold: assert property (p_m1_rx_hold) else $error("mode 1 rx ready released early"); // R7
  property p_clear_tx;
    @(posedge CLK_I) disable iff (RST_I) tx_clear |=> (tx_cnt == '0 && !tx_clear);
  endproperty
  a_clear_tx: assert property (p_clear_tx) else $error("tx clear failed"); // R8 R10
  property p_clear_rx;
    @(posedge CLK_I) disable iff (RST_I) rx_clear |=> (rx_cnt == '0 && !rx_clear);
  endproperty
  a_clear_rx: assert property (p_clear_rx) else $error("rx clear failed"); // R9
  property p_guard;
    @(posedge CLK_I) disable iff (RST_I) (wr_acc && PADDR_I == `UFC_ADDR_SETUP && !PWDATA_I[`UFC_BIT_FEN])
      |=> (fifo_setup[`UFC_BIT_DMA] == $past(fifo_setup[`UFC_BIT_DMA]) && !tx_clear && !rx_clear);
  endproperty
  a_guard: assert property (p_guard) else $error("setup written without enable"); // R12
  c_full: cover property (@(posedge CLK_I) rx_cnt == FULL_CNT);
  c_m1: cover property (@(posedge CLK_I) dma1 && !RX_CHAR_AVAIL_N_O);
  c_clr: cover property (@(posedge CLK_I) tx_clear && tx_cnt != '0);
endmodule // ufc_fifo_ctrl

// file: src/ufc_pkg.sv
// types of the uart fifo control block
package ufc_pkg;
  // receive ready state in block mode
  typedef enum logic [0:0] {UFC_RX_IDLE, UFC_RX_ACTIVE} ufc_rx_state_t;
endpackage

// file: verification/uart_fifo_control_tb.sv
// self-checking bench of the uart fifo control block
`timescale 1ns/1ps
`include "ufc_consts.svh"
`define CHK(nm, ex, sn) begin cmp_count++; if ((sn) !== (ex)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, ex, sn); end end
module uart_fifo_control_tb;
  logic CLK_I, RST_I, psel, penable, pwrite, tx_load, rx_read, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, tx_has, rxn, txn, rx_irq, irq, st, tt, to;
  logic [7:0] tx_data, tx_head, rx_head, sd;
  logic [4:0] lvl [4] = '{`UFC_TRIG_1, `UFC_TRIG_4, `UFC_TRIG_8, `UFC_TRIG_14};
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  // ************
  // dut and far side
  // ************
  ufc_fifo_ctrl DUT (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .TX_LOAD_I(tx_load), .TX_DATA_I(tx_data), .TX_TAKE_I(tt), .TX_HEAD_O(tx_head), .TX_HAS_DATA_O(tx_has),
    .RX_STORE_I(st), .RX_DATA_I(sd), .RX_READ_I(rx_read), .RX_TIMEOUT_I(to), .RX_HEAD_O(rx_head),
    .TX_SPACE_AVAIL_N_O(txn), .RX_CHAR_AVAIL_N_O(rxn), .RX_DATA_IRQ_O(rx_irq), .IRQ_O(irq));
  ufc_far_model u_far (.clk_i(CLK_I), .rx_store_o(st), .rx_data_o(sd), .tx_take_o(tt), .rx_timeout_o(to));
  // clock of 8 ns
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  // hang guard
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ************
  // tasks
  // ************
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer, held until pready; only the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK_I);
    penable <= 1'b1;
    do begin
      @(posedge CLK_I);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // let counts and pins land
  task automatic settle();
    repeat (2) @(posedge CLK_I);
    #1;
  endtask
  // host loads (ld=1) or reads n bytes back to back
  task automatic host(input logic ld, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK_I);
      tx_load <= ld;
      rx_read <= ~ld;
      tx_data <= 8'hA0 + 8'(i);
    end
    @(posedge CLK_I);
    tx_load <= 1'b0;
    rx_read <= 1'b0;
    settle();
  endtask
  // ************
  // main sequence
  // ************
  initial begin
    {psel, penable, pwrite, tx_load, rx_read} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tx_data = 8'h00;
    RST_I = 1'b1;
    repeat (6) @(posedge CLK_I);
    RST_I <= 1'b0;
    rd(`UFC_ADDR_SETUP);
    `CHK("setup", 8'h00, rdata[7:0])
    `CHK("txn", 1'b0, txn)
    `CHK("rxn", 1'b1, rxn)
    u_far.store(2, 8'h10);
    settle();
    `CHK("rxn", 1'b0, rxn)
    `CHK("rxhead", 8'h10, rx_head)
    rd(`UFC_ADDR_STATUS);
    `CHK("rxcnt", 5'h01, rdata[12:8])
    host(1'b1, 1);
    `CHK("txn", 1'b1, txn)
    `CHK("txhas", 1'b1, tx_has)
    `CHK("txhead", 8'hA0, tx_head)
    wr(`UFC_ADDR_SETUP, 32'h0000_0007);
    rd(`UFC_ADDR_SETUP);
    `CHK("setup", 8'h01, rdata[7:0])
    rd(`UFC_ADDR_STATUS);
    `CHK("counts", 10'h000, {rdata[20:16], rdata[12:8]})
    $display("test single mode done");
    for (int c = 0; c < 4; c++) begin
      wr(`UFC_ADDR_SETUP, 32'({2'(c), 6'h03}));
      u_far.store(int'(lvl[c]) - 1, 8'h20);
      settle();
      `CHK("rxirq", 1'b0, rx_irq)
      u_far.store(1, 8'h40);
      settle();
      `CHK("rxirq", 1'b1, rx_irq)
    end
    u_far.store(4, 8'h50);
    settle();
    rd(`UFC_ADDR_STATUS);
    `CHK("rxcnt", 5'h10, rdata[12:8])
    host(1'b0, 2);
    `CHK("rxirq", 1'b1, rx_irq)
    host(1'b0, 1);
    `CHK("rxirq", 1'b0, rx_irq)
    $display("test trigger done");
    rd(`UFC_ADDR_IRQ_STAT);
    `CHK("irqstat", 3'h5, rdata[2:0])
    wr(`UFC_ADDR_IRQ_EN, 32'h0000_0001);
    wr(`UFC_ADDR_IRQ_CLR, 32'h0000_0007);
    settle();
    `CHK("irq", 1'b0, irq)
    u_far.store(1, 8'h60);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(`UFC_ADDR_IRQ_EN, 32'h0000_0000);
    settle();
    `CHK("irq", 1'b0, irq)
    wr(`UFC_ADDR_IRQ_EN, 32'h0000_0001);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(`UFC_ADDR_IRQ_CLR, 32'h0000_0001);
    settle();
    `CHK("irq", 1'b0, irq)
    rd(`UFC_ADDR_IRQ_STAT);
    `CHK("irqstat", 1'b0, rdata[0])
    rd(12'h020);
    `CHK("slverr", 1'b1, rerr)
    $display("test interrupt done");
    wr(`UFC_ADDR_SETUP, 32'h0000_00CA);
    rd(`UFC_ADDR_SETUP);
    `CHK("setup", 8'hC0, rdata[7:0])
    rd(`UFC_ADDR_STATUS);
    `CHK("rxcnt", 5'h0E, rdata[12:8])
    $display("test write guard done");
    wr(`UFC_ADDR_SETUP, 32'h0000_004F);
    rd(`UFC_ADDR_SETUP);
    `CHK("setup", 8'h49, rdata[7:0])
    settle();
    `CHK("rxn", 1'b1, rxn)
    `CHK("txn", 1'b0, txn)
    u_far.store(3, 8'h70);
    settle();
    `CHK("rxn", 1'b1, rxn)
    u_far.timeout();
    settle();
    `CHK("rxn", 1'b0, rxn)
    host(1'b0, 3);
    `CHK("rxn", 1'b1, rxn)
    u_far.store(4, 8'h80);
    host(1'b0, 1);
    `CHK("rxn", 1'b0, rxn)
    host(1'b1, 1);
    `CHK("txn", 1'b0, txn)
    host(1'b1, 16);
    `CHK("txn", 1'b1, txn)
    u_far.take();
    settle();
    `CHK("txn", 1'b1, txn)
    wr(`UFC_ADDR_SETUP, 32'h0000_004D);
    settle();
    `CHK("txn", 1'b0, txn)
    rd(`UFC_ADDR_STATUS);
    `CHK("counts", 10'h003, {rdata[20:16], rdata[12:8]})
    $display("test block mode done");
    end_sim();
  end
endmodule // uart_fifo_control_tb

// file: verification/ufc_far_model.sv
// far side model: deserializer and serializer strobes of the uart
`timescale 1ns/1ps
module ufc_far_model #(
  parameter int WIDTH = 8
) (
  // clock
  input wire logic clk_i,
  // strobes into the block
  output logic rx_store_o,
  output logic [WIDTH-1:0] rx_data_o,
  output logic tx_take_o,
  output logic rx_timeout_o
);
  logic [WIDTH-1:0] last; // last byte put on the line
  // idle strobes at time zero
  initial begin
    rx_store_o = 1'b0;
    rx_data_o = 8'h5A;
    tx_take_o = 1'b0;
    rx_timeout_o = 1'b0;
    last = 8'h5A;
  end
  // store n bytes back to back, counting up from base
  task automatic store(input int n, input logic [WIDTH-1:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      last = base + WIDTH'(i);
      rx_store_o <= 1'b1;
      rx_data_o <= last;
    end
    @(posedge clk_i);
    rx_store_o <= 1'b0;
    rx_data_o <= ~last; // released line shows no stale byte
  endtask
  // serializer takes one byte
  task automatic take();
    @(posedge clk_i);
    tx_take_o <= 1'b1;
    @(posedge clk_i);
    tx_take_o <= 1'b0;
  endtask
  // one cycle of receive time-out
  task automatic timeout();
    @(posedge clk_i);
    rx_timeout_o <= 1'b1;
    @(posedge clk_i);
    rx_timeout_o <= 1'b0;
  endtask
endmodule // ufc_far_model
